// file: rtl/bpc_command.sv
// Primary command register, identification field and derived enables
`timescale 1ns/1ns
module bpc_command (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        cfg_write,
    input  wire logic        cfg_read,
    input  wire logic [7:0]  cfg_addr,
    input  wire logic [31:0] cfg_wdata,
    input  wire logic [3:0]  cfg_be,
    output logic      [31:0] cfg_rdata,
    input  wire logic        fwd_mwi,
    input  wire logic        prim_io_cycle,
    input  wire logic        prim_mem_cycle,
    input  wire logic        prim_io_write,
    input  wire logic [15:0] prim_addr,
    input  wire logic        sec_io_cycle,
    input  wire logic        sec_mem_cycle,
    input  wire logic        fwd_request,
    input  wire logic        fbb_request,
    input  wire logic        perr_detected,
    input  wire logic        primary_parity_error_n,
    input  wire logic        serr_request,
    output logic             prim_io_claim,
    output logic             prim_mem_claim,
    output logic             palette_claim,
    output logic             sec_claim,
    output logic             prim_master_go,
    output logic             fbb_allow,
    output logic             perr_action,
    output logic             primary_system_error_n_o,
    output logic             primary_system_error_n_oe,
    output logic             data_parity_flag
);
    import bpc_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [15:0] cmd_r, cmd_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic        dpe_r, dpe_nxt;
    logic        io_claim_r, io_claim_nxt;
    logic        mem_claim_r, mem_claim_nxt;
    logic        pal_r, pal_nxt;
    logic        sec_r, sec_nxt;
    logic        mgo_r, mgo_nxt;
    logic        fbb_r, fbb_nxt;
    logic        pact_r, pact_nxt;
    logic        serr_oe_r, serr_oe_nxt;
    logic        pal_hit;
    logic [15:0] cmd_view;

    bpc_palette_decode u_pal (
        .io_addr     (prim_addr),
        .io_write    (prim_io_write),
        .snoop_en    (cmd_r[BPC_BIT_PALETTE]),
        .palette_hit (pal_hit)
    );

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    // Strobe aimed at the command and status dword
    function automatic logic cmd_dword_write(input logic       wr_strobe,
                                             input logic [7:0] addr);
        return wr_strobe && (addr == BPC_OFF_COMMAND);
    endfunction

    // One byte lane of the command word; masked bits always come back zero
    function automatic logic [7:0] lane_merge(input logic [7:0] old_val,
                                              input logic [7:0] new_val,
                                              input logic [7:0] wr_mask,
                                              input logic       lane_en);
        logic [7:0] merged;
        merged = old_val;
        if (lane_en) begin
            merged = new_val & wr_mask;
        end
        return merged;
    endfunction

    // ------------------------------------------------------------
    // Command register
    // ------------------------------------------------------------
    always_comb begin
        cmd_nxt = cmd_r;
        // Read-only and reserved bits are masked off on every write
        if (cmd_dword_write(cfg_write, cfg_addr)) begin
            cmd_nxt[7:0]  = lane_merge(cmd_r[7:0], cfg_wdata[7:0],
                                       BPC_CMD_WR_MASK[7:0], cfg_be[0]);
            cmd_nxt[15:8] = lane_merge(cmd_r[15:8], cfg_wdata[15:8],
                                       BPC_CMD_WR_MASK[15:8], cfg_be[1]);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cmd_r <= BPC_CMD_RESET;
        end else begin
            cmd_r <= cmd_nxt;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Read data stands for one cycle and is zero otherwise, so a late
    // sampler sees zeros rather than a stale word
    always_comb begin
        // Bit 4 is a live view of forwarding, never stored
        cmd_view              = cmd_r;
        cmd_view[BPC_BIT_MWI] = fwd_mwi;
        rdata_nxt             = 32'h0000_0000;
        if (cfg_read) begin
            case (cfg_addr)
                BPC_OFF_IDENT: begin
                    // Low half belongs to another block and reads zero here
                    rdata_nxt = {BPC_DEVICE_IDENTIFIER, 16'h0000};
                end
                BPC_OFF_COMMAND: begin
                    rdata_nxt = {7'h00, dpe_r, 8'h00, cmd_view};
                end
                default: begin
                    rdata_nxt = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // Data parity flag
    // ------------------------------------------------------------
    always_comb begin
        dpe_nxt = dpe_r;
        // Write one to clear through byte lane 3
        if (cmd_dword_write(cfg_write, cfg_addr) && cfg_be[3] && cfg_wdata[BPC_BIT_DPE]) begin
            dpe_nxt = 1'b0;
        end
        // Hardware set wins over a clear in the same cycle, so no error is lost
        if (!primary_parity_error_n && cmd_r[BPC_BIT_PERR_EN]) begin
            dpe_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            dpe_r <= 1'b0;
        end else begin
            dpe_r <= dpe_nxt;
        end
    end

    // ------------------------------------------------------------
    // Derived enables
    // ------------------------------------------------------------
    // Enables lag their inputs by one cycle; the forwarding logic around
    // this block must allow for that registered stage
    always_comb begin
        io_claim_nxt  = prim_io_cycle && cmd_r[BPC_BIT_IO_EN];
        mem_claim_nxt = prim_mem_cycle && cmd_r[BPC_BIT_MEM_EN];
        pal_nxt       = prim_io_cycle && pal_hit;
        sec_nxt       = (sec_io_cycle || sec_mem_cycle) && cmd_r[BPC_BIT_MASTER];
        mgo_nxt       = fwd_request && cmd_r[BPC_BIT_MASTER];
        // Stepping stays off, so fast back-to-back needs only its enable
        fbb_nxt       = fbb_request && cmd_r[BPC_BIT_FBB_EN];
        pact_nxt      = perr_detected && cmd_r[BPC_BIT_PERR_EN];
        serr_oe_nxt   = serr_request && cmd_r[BPC_BIT_SERR_EN];
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            io_claim_r  <= 1'b0;
            mem_claim_r <= 1'b0;
            pal_r       <= 1'b0;
            sec_r       <= 1'b0;
            mgo_r       <= 1'b0;
            fbb_r       <= 1'b0;
            pact_r      <= 1'b0;
            serr_oe_r   <= 1'b0;
        end else begin
            io_claim_r  <= io_claim_nxt;
            mem_claim_r <= mem_claim_nxt;
            pal_r       <= pal_nxt;
            sec_r       <= sec_nxt;
            mgo_r       <= mgo_nxt;
            fbb_r       <= fbb_nxt;
            pact_r      <= pact_nxt;
            serr_oe_r   <= serr_oe_nxt;
        end
    end

    assign cfg_rdata                 = rdata_r;
    assign prim_io_claim             = io_claim_r;
    assign prim_mem_claim            = mem_claim_r;
    assign palette_claim             = pal_r;
    assign sec_claim                 = sec_r;
    assign prim_master_go            = mgo_r;
    assign fbb_allow                 = fbb_r;
    assign perr_action               = pact_r;
    // Open drain: output is always low, enable carries the assertion
    assign primary_system_error_n_o  = 1'b0;
    assign primary_system_error_n_oe = serr_oe_r;
    assign data_parity_flag          = dpe_r;
endmodule // bpc_command

// file: pkg/bpc_pkg.sv
// Package: offsets, field positions and constants of the primary command register block
package bpc_pkg;
    localparam logic [7:0]  BPC_OFF_IDENT    = 8'h00;
    localparam logic [7:0]  BPC_OFF_COMMAND  = 8'h04;
    localparam int          BPC_BIT_IO_EN    = 0;
    localparam int          BPC_BIT_MEM_EN   = 1;
    localparam int          BPC_BIT_MASTER   = 2;
    localparam int          BPC_BIT_SPECIAL  = 3;
    localparam int          BPC_BIT_MWI      = 4;
    localparam int          BPC_BIT_PALETTE  = 5;
    localparam int          BPC_BIT_PERR_EN  = 6;
    localparam int          BPC_BIT_STEP     = 7;
    localparam int          BPC_BIT_SERR_EN  = 8;
    localparam int          BPC_BIT_FBB_EN   = 9;
    localparam int          BPC_BIT_DPE      = 24;
    localparam logic [15:0] BPC_CMD_RESET    = 16'h0000;
    localparam logic [15:0] BPC_CMD_WR_MASK  = 16'h0367;
    localparam logic [9:0]  BPC_PAL_ADDR_A   = 10'h3c6;
    localparam logic [9:0]  BPC_PAL_ADDR_B   = 10'h3c8;
    localparam logic [9:0]  BPC_PAL_ADDR_C   = 10'h3c9;
    // Arbitrary neutral identification value
    localparam logic [15:0] BPC_DEVICE_IDENTIFIER    = 16'h5a01;
endpackage

// file: rtl/bpc_palette_decode.sv
// Palette snoop address decoder
`timescale 1ns/1ns
module bpc_palette_decode (
    input  wire logic [15:0] io_addr,
    input  wire logic        io_write,
    input  wire logic        snoop_en,
    output logic             palette_hit
);
    import bpc_pkg::*;

    // Upper address bits ignored so ISA aliases also hit
    always_comb begin
        palette_hit = snoop_en && io_write &&
                      ((io_addr[9:0] == BPC_PAL_ADDR_A) ||
                       (io_addr[9:0] == BPC_PAL_ADDR_B) ||
                       (io_addr[9:0] == BPC_PAL_ADDR_C));
    end
endmodule // bpc_palette_decode

// file: dv/bpc_command_sva.sv
// Port checker for the primary command register block
`timescale 1ns/1ns
module bpc_command_sva
    import bpc_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic        cfg_read,
    input wire logic [7:0]  cfg_addr,
    input wire logic [31:0] cfg_rdata,
    input wire logic        prim_io_cycle,
    input wire logic        prim_io_write,
    input wire logic [15:0] prim_addr,
    input wire logic        prim_io_claim,
    input wire logic        palette_claim,
    input wire logic        sec_io_cycle,
    input wire logic        sec_mem_cycle,
    input wire logic        sec_claim,
    input wire logic        fbb_request,
    input wire logic        fbb_allow,
    input wire logic        serr_request,
    input wire logic        primary_system_error_n_o,
    input wire logic        primary_system_error_n_oe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    chk_ident_read: assert property ($past(cfg_read && cfg_addr == BPC_OFF_IDENT)
        |-> cfg_rdata == {BPC_DEVICE_IDENTIFIER, 16'h0000}) else $error("ident read wrong");
    chk_fixed_zero: assert property ($past(cfg_read && cfg_addr == BPC_OFF_COMMAND)
        |-> cfg_rdata[15:10] == 6'h00 && !cfg_rdata[7] && !cfg_rdata[3]) else $error("fixed bits set");
    chk_io_cause: assert property (prim_io_claim |-> $past(prim_io_cycle)) else $error("io claim");
    chk_palette_cause: assert property (palette_claim |-> $past(prim_io_cycle && prim_io_write
        && prim_addr[9:0] inside {10'h3c6, 10'h3c8, 10'h3c9})) else $error("palette claim");
    chk_sec_cause: assert property (sec_claim |-> $past(sec_io_cycle || sec_mem_cycle)) else $error("sec");
    chk_fbb_cause: assert property (fbb_allow |-> $past(fbb_request)) else $error("fbb");
    chk_serr_cause: assert property (primary_system_error_n_oe |-> $past(serr_request)) else $error("oe");
    chk_serr_level: assert property (primary_system_error_n_oe |-> !primary_system_error_n_o) else $error("lvl");
    cover property (palette_claim);
    cover property (fbb_allow);
    cover property (primary_system_error_n_oe);
endmodule // bpc_command_sva

bind bpc_command bpc_command_sva chk (.*);

// file: dv/bpc_cfg_master.sv
// Configuration master model on the primary bus
`timescale 1ns/1ns
module bpc_cfg_master (
    input  wire logic        clk_sys,
    input  wire logic [31:0] cfg_rdata,
    output logic             cfg_write = 1'b0,
    output logic             cfg_read  = 1'b0,
    output logic      [7:0]  cfg_addr  = 8'hff,
    output logic      [31:0] cfg_wdata = 32'h0,
    output logic      [3:0]  cfg_be    = 4'h0
);
    // Released address and data lines flip so stale values never pass
    task automatic done();
        cfg_write = 1'b0;
        cfg_read  = 1'b0;
        cfg_addr  = ~cfg_addr;
        cfg_wdata = ~cfg_wdata;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        {cfg_addr, cfg_wdata, cfg_be, cfg_write} = {a, d, be, 1'b1};
        @(posedge clk_sys);
        #1;
        done();
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        {cfg_addr, cfg_read} = {a, 1'b1};
        @(posedge clk_sys);
        #1;
        d = cfg_rdata;
        done();
    endtask
endmodule // bpc_cfg_master

// file: dv/bpc_command_tb.sv
// Self-checking bench for the primary command register block
`timescale 1ns/1ns
module bpc_command_tb;
    import bpc_pkg::*;
    logic clk_sys = 1'b0, reset = 1'b1, fwd_mwi = 1'b0, primary_parity_error_n = 1'b1;
    logic cfg_write, cfg_read, prim_io_cycle, prim_mem_cycle, prim_io_write, sec_io_cycle, sec_mem_cycle;
    logic fwd_request, fbb_request, perr_detected, serr_request, prim_io_claim, prim_mem_claim, palette_claim;
    logic sec_claim, prim_master_go, fbb_allow, perr_action, primary_system_error_n_o, primary_system_error_n_oe;
    logic data_parity_flag;
    logic [7:0]  cfg_addr;
    logic [3:0]  cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata;
    logic [15:0] prim_addr = 16'hffc6;
    logic [8:0]  lv = 9'h000;
    int          miscompares = 0, n_compared = 0, cyc = 0;
    assign {prim_io_cycle, prim_mem_cycle, prim_io_write, sec_io_cycle, sec_mem_cycle, fwd_request,
            fbb_request, perr_detected, serr_request} = lv;
    bpc_command DUT (.*);
    bpc_cfg_master M (.*);
    initial forever #5 clk_sys = ~clk_sys;
    // Tests take under two hundred cycles; the ceiling leaves wide margin
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            miscompares++;
            final_report();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin miscompares++; $display("Error %0t: got %h exp %h", $time, got, exp); end
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        M.rd(a, d);
        chk(d, e);
    endtask
    task automatic lvl(input logic [8:0] v, input logic [7:0] e);
        lv = v;
        @(posedge clk_sys);
        #1;
        // Open-drain level must stay low whatever the enable does
        chk({23'h0, primary_system_error_n_o, prim_io_claim, prim_mem_claim, palette_claim, sec_claim,
             prim_master_go, fbb_allow, perr_action, primary_system_error_n_oe}, {24'h0, e});
    endtask
    task automatic perr_pulse();
        primary_parity_error_n = 1'b0;
        @(posedge clk_sys);
        #1;
        primary_parity_error_n = 1'b1;
    endtask
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge clk_sys);
        #1;
        reset = 1'b0;
        rc(BPC_OFF_IDENT, {BPC_DEVICE_IDENTIFIER, 16'h0000});
        rc(BPC_OFF_COMMAND, 32'h0);
        M.wr(BPC_OFF_IDENT, 32'hffffffff, 4'hf);
        rc(BPC_OFF_IDENT, {BPC_DEVICE_IDENTIFIER, 16'h0000});
        rc(8'h08, 32'h0);
        $display("test reset and ident done");
        M.wr(BPC_OFF_COMMAND, 32'hffffffff, 4'hf);
        rc(BPC_OFF_COMMAND, 32'h0367);
        fwd_mwi = 1'b1;
        rc(BPC_OFF_COMMAND, 32'h0377);
        fwd_mwi = 1'b0;
        lvl(9'h1ff, 8'hff);
        prim_addr = 16'h03c8;
        lvl(9'h140, 8'ha0);
        prim_addr = 16'h7fc9;
        lvl(9'h140, 8'ha0);
        lvl(9'h100, 8'h80);
        prim_addr = 16'h03c7;
        lvl(9'h140, 8'h80);
        $display("test enables done");
        M.wr(BPC_OFF_COMMAND, 32'h0, 4'h2);
        rc(BPC_OFF_COMMAND, 32'h0067);
        prim_addr = 16'h03c6;
        lvl(9'h1ff, 8'hfa);
        M.wr(BPC_OFF_COMMAND, 32'h0, 4'hf);
        lvl(9'h1ff, 8'h00);
        M.wr(BPC_OFF_COMMAND, 32'h40, 4'h1);
        perr_pulse();
        chk({31'h0, data_parity_flag}, 32'h1);
        rc(BPC_OFF_COMMAND, 32'h01000040);
        M.wr(BPC_OFF_COMMAND, 32'h01000000, 4'h8);
        rc(BPC_OFF_COMMAND, 32'h40);
        chk({31'h0, data_parity_flag}, 32'h0);
        M.wr(BPC_OFF_COMMAND, 32'h0, 4'h1);
        perr_pulse();
        rc(BPC_OFF_COMMAND, 32'h0);
        chk({31'h0, data_parity_flag}, 32'h0);
        $display("test parity flag done");
        final_report();
    end
endmodule // bpc_command_tb
